// >>> hw/pcl_pkg.sv
// Functional notes
// - program counter fifteen bits, low byte readable/writable
// - upper bits written by software only via high latch
// - any reset clears whole program counter
// - low byte destination copies latch upward
// - low byte write changes all bits together
// - computed add sums into low byte only, upper bits loaded from latch
// - direct call: operand low, latch bits six-three
// - working-register call: low from working, upper latch
// - copies keep contents across external pin reset
// - unimplemented addresses read as zero
// - sixteen entry fifteen bit return stack
// - stack pointer field five bits wide
// - push increments first, pop decrements after
// - stack top registers access selected entry
package pcl_pkg;
  localparam logic [12:0] ADDR_STATUS_COPY = 13'h1fe4;
  localparam logic [12:0] ADDR_WORKING_COPY = 13'h1fe5;
  localparam logic [12:0] ADDR_BANK_COPY = 13'h1fe6;
  localparam logic [12:0] ADDR_LATCH_COPY = 13'h1fe7;
  localparam logic [12:0] ADDR_PTR0L_COPY = 13'h1fe8;
  localparam logic [12:0] ADDR_PTR0H_COPY = 13'h1fe9;
  localparam logic [12:0] ADDR_PTR1L_COPY = 13'h1fea;
  localparam logic [12:0] ADDR_PTR1H_COPY = 13'h1feb;
  localparam logic [12:0] ADDR_STACK_PTR = 13'h1fed;
  localparam logic [12:0] ADDR_STACK_TOP_LOW = 13'h1fee;
  localparam logic [12:0] ADDR_STACK_TOP_HIGH = 13'h1fef;
  // own choices: program counter window and latch
  localparam logic [12:0] ADDR_PC_LOW = 13'h0002;
  localparam logic [12:0] ADDR_PC_LATCH = 13'h000a;
  localparam logic [4:0] STACK_PTR_RESET = 5'h1c;
  localparam logic [14:0] PC_RESET = 15'h0000;
  localparam logic [14:0] PC_IRQ_VECTOR = 15'h0004;
  localparam int STACK_DEPTH = 16;

  // program counter operation codes from the core sequencer
  typedef enum logic [2:0]
  {
    PC_OP_STEP   = 3'b000,
    PC_OP_CALL   = 3'b001,
    PC_OP_CALL_VIA_WORKING_REG  = 3'b010,
    PC_OP_RETURN = 3'b011,
    PC_OP_IRQ    = 3'b100,
    PC_OP_ADDLOW = 3'b101,
    PC_OP_HOLD   = 3'b110
  } pcl_op_e;

  typedef struct packed
  {
    logic [7:0] status;
    logic [7:0] working;
    logic [7:0] bank;
    logic [7:0] ptr0_low;
    logic [7:0] ptr0_high;
    logic [7:0] ptr1_low;
    logic [7:0] ptr1_high;
  } pcl_ctx_s;
endpackage

// >>> hw/pcl_unit.sv
`timescale 1ns/100ps
module pcl_unit
  import pcl_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        ext_pin_reset_b,
  input  wire logic        op_valid,
  input  wire pcl_op_e     op_code,
  input  wire logic [10:0] call_operand,
  input  wire logic [7:0]  add_value,
  input  wire pcl_ctx_s    core_ctx,
  input  wire logic [12:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  output logic [14:0]      program_counter
);

  logic [14:0] pc_r;
  logic [6:0]  pc_high_latch_r;
  logic [4:0]  stack_ptr_r;
  logic [14:0] stack_mem [STACK_DEPTH];
  pcl_ctx_s    ctx_copy_r;
  logic [6:0]  latch_copy_r;
  logic [7:0]  rdata_r;
  logic        push;
  logic        pop;
  logic        wr_low;
  logic [4:0]  ptr_up;
  logic [3:0]  top_idx;
  logic [14:0] top_val;
  logic [14:0] pc_nxt;
  logic        pin_s1_r;
  logic        pin_s2_r;

  // all checks below share the one clock and the power-on reset
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // stack ops are ignored while the pin reset holds the counter at zero
  assign push    = op_valid && pin_s2_r && (op_code == PC_OP_CALL ||
                   op_code == PC_OP_CALL_VIA_WORKING_REG || op_code == PC_OP_IRQ);
  assign pop     = op_valid && pin_s2_r && op_code == PC_OP_RETURN;
  assign wr_low  = reg_wr && reg_addr == ADDR_PC_LOW;
  assign ptr_up  = 5'(stack_ptr_r + 5'h01);
  assign top_idx = stack_ptr_r[3:0];
  assign top_val = stack_mem[top_idx];

  // program counter next value; register write wins over sequencer
  always_comb
  begin
    pc_nxt = pc_r;
    if (wr_low)
      pc_nxt = {pc_high_latch_r, reg_wdata};
    else if (op_valid)
    begin
      case (op_code)
        PC_OP_STEP:   pc_nxt = 15'(pc_r + 15'h0001);
        PC_OP_CALL:   pc_nxt = {pc_high_latch_r[6:3], call_operand};
        PC_OP_CALL_VIA_WORKING_REG:  pc_nxt = {pc_high_latch_r, add_value};
        PC_OP_RETURN: pc_nxt = top_val;
        PC_OP_IRQ:    pc_nxt = PC_IRQ_VECTOR;
        // carry out of the low byte is dropped on purpose
        PC_OP_ADDLOW: pc_nxt = {pc_high_latch_r,
                                8'(pc_r[7:0] + add_value)};
        default:      pc_nxt = pc_r;
      endcase
    end
  end

  // program counter cleared by every reset source
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      pc_r <= PC_RESET;
    else if (!pin_s2_r)
      pc_r <= PC_RESET;
    else
      pc_r <= pc_nxt;
  end

  // external pin synchroniser
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end
    else
    begin
      pin_s1_r <= ext_pin_reset_b;
      pin_s2_r <= pin_s1_r;
    end
  end

  // high latch, only register-write path to upper bits
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      pc_high_latch_r <= 7'h00;
    else if (reg_wr && reg_addr == ADDR_PC_LATCH)
      pc_high_latch_r <= reg_wdata[6:0];
  end

  // stack pointer, five bits so wrap is detectable
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      stack_ptr_r <= STACK_PTR_RESET;
    else if (reg_wr && reg_addr == ADDR_STACK_PTR)
      stack_ptr_r <= reg_wdata[4:0];
    else if (push)
      stack_ptr_r <= ptr_up;
    else if (pop)
      stack_ptr_r <= 5'(stack_ptr_r - 5'h01);
  end

  // stack array has no reset; survives pin reset
  always_ff @(posedge clk_sys)
  begin
    if (push)
      stack_mem[ptr_up[3:0]] <= (op_code == PC_OP_IRQ) ? pc_r
                                : 15'(pc_r + 15'h0001);
    else if (reg_wr && reg_addr == ADDR_STACK_TOP_LOW)
      stack_mem[top_idx] <= {top_val[14:8], reg_wdata};
    else if (reg_wr && reg_addr == ADDR_STACK_TOP_HIGH)
      stack_mem[top_idx] <= {reg_wdata[6:0], top_val[7:0]};
  end

  // context copies: no reset, so pin reset leaves them intact
  always_ff @(posedge clk_sys)
  begin
    if (op_valid && op_code == PC_OP_IRQ)
    begin
      ctx_copy_r   <= core_ctx;
      latch_copy_r <= pc_high_latch_r;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        ADDR_STATUS_COPY:  ctx_copy_r.status <= {5'h00, reg_wdata[2:0]};
        ADDR_WORKING_COPY: ctx_copy_r.working <= reg_wdata;
        ADDR_BANK_COPY:    ctx_copy_r.bank <= {3'h0, reg_wdata[4:0]};
        ADDR_LATCH_COPY:   latch_copy_r <= reg_wdata[6:0];
        ADDR_PTR0L_COPY:   ctx_copy_r.ptr0_low <= reg_wdata;
        ADDR_PTR0H_COPY:   ctx_copy_r.ptr0_high <= reg_wdata;
        ADDR_PTR1L_COPY:   ctx_copy_r.ptr1_low <= reg_wdata;
        ADDR_PTR1H_COPY:   ctx_copy_r.ptr1_high <= reg_wdata;
        default:           ctx_copy_r <= ctx_copy_r;
      endcase
    end
  end

  // read data one cycle after strobe, zero elsewhere
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      rdata_r <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        ADDR_PC_LOW:         rdata_r <= pc_r[7:0];
        ADDR_PC_LATCH:       rdata_r <= {1'b0, pc_high_latch_r};
        ADDR_STATUS_COPY:    rdata_r <= {5'h00, ctx_copy_r.status[2:0]};
        ADDR_WORKING_COPY:   rdata_r <= ctx_copy_r.working;
        ADDR_BANK_COPY:      rdata_r <= {3'h0, ctx_copy_r.bank[4:0]};
        ADDR_LATCH_COPY:     rdata_r <= {1'b0, latch_copy_r};
        ADDR_PTR0L_COPY:     rdata_r <= ctx_copy_r.ptr0_low;
        ADDR_PTR0H_COPY:     rdata_r <= ctx_copy_r.ptr0_high;
        ADDR_PTR1L_COPY:     rdata_r <= ctx_copy_r.ptr1_low;
        ADDR_PTR1H_COPY:     rdata_r <= ctx_copy_r.ptr1_high;
        ADDR_STACK_PTR:      rdata_r <= {3'h0, stack_ptr_r};
        ADDR_STACK_TOP_LOW:  rdata_r <= top_val[7:0];
        ADDR_STACK_TOP_HIGH: rdata_r <= {1'b0, top_val[14:8]};
        default:             rdata_r <= 8'h00;
      endcase
    end
    else
      rdata_r <= 8'h00;
  end

  assign reg_rdata       = rdata_r;
  assign program_counter = pc_r;

  // steps of a call followed by its return, no bus write in between
  sequence s_call_go;
    op_valid && op_code == PC_OP_CALL && !reg_wr && pin_s2_r;
  endsequence

  sequence s_idle_gap;
    !op_valid && !reg_wr && pin_s2_r;
  endsequence

  sequence s_ret_go;
    op_valid && op_code == PC_OP_RETURN && !reg_wr && pin_s2_r;
  endsequence

  // program counter loads
  a_low_write_pc: assert property (
    wr_low && pin_s2_r |=> pc_r == {$past(pc_high_latch_r),
                                    $past(reg_wdata)})
    else $error("low write did not load latch and byte");

  a_call_load: assert property (
    !wr_low && pin_s2_r && op_valid && op_code == PC_OP_CALL |=>
    pc_r == {$past(pc_high_latch_r[6:3]), $past(call_operand)})
    else $error("direct call target wrong");

  a_call_via_working_reg_load: assert property (
    !wr_low && pin_s2_r && op_valid && op_code == PC_OP_CALL_VIA_WORKING_REG |=>
    pc_r == {$past(pc_high_latch_r), $past(add_value)})
    else $error("working call target wrong");

  a_add_upper: assert property (
    !wr_low && pin_s2_r && op_valid && op_code == PC_OP_ADDLOW |=>
    pc_r[14:8] == $past(pc_high_latch_r))
    else $error("computed add upper bits wrong");

  a_add_low: assert property (
    !wr_low && pin_s2_r && op_valid && op_code == PC_OP_ADDLOW |=>
    pc_r[7:0] == 8'($past(pc_r[7:0]) + $past(add_value)))
    else $error("computed add low byte wrong");

  a_step_incr: assert property (
    !wr_low && pin_s2_r && op_valid && op_code == PC_OP_STEP |=>
    pc_r == 15'($past(pc_r) + 15'h0001))
    else $error("step did not advance counter");

  a_hold_keep: assert property (
    !wr_low && pin_s2_r && op_valid && op_code == PC_OP_HOLD |=>
    pc_r == $past(pc_r))
    else $error("hold changed counter");

  a_irq_vector: assert property (
    !wr_low && pin_s2_r && op_valid && op_code == PC_OP_IRQ |=>
    pc_r == PC_IRQ_VECTOR)
    else $error("interrupt vector wrong");

  a_return_load: assert property (
    !wr_low && pop |=> pc_r == $past(top_val))
    else $error("return target wrong");

  a_call_return: assert property (
    s_call_go ##1 s_idle_gap ##1 s_ret_go |=>
    pc_r == 15'($past(pc_r, 3) + 15'h0001))
    else $error("return did not resume after call");

  a_pin_reset_pc: assert property (
    !pin_s2_r |=> pc_r == 15'h0000)
    else $error("pin reset did not clear counter");

  // stack pointer and stack entries
  a_push_pointer: assert property (
    push && !reg_wr |=> stack_ptr_r == 5'($past(stack_ptr_r) + 5'h01))
    else $error("push pointer not incremented");

  a_pop_pointer: assert property (
    pop && !reg_wr |=> stack_ptr_r == 5'($past(stack_ptr_r) - 5'h01))
    else $error("pop pointer not decremented");

  a_call_store: assert property (
    push && !reg_wr && op_code != PC_OP_IRQ |=>
    top_val == 15'($past(pc_r) + 15'h0001))
    else $error("call pushed wrong return address");

  a_irq_store: assert property (
    push && !reg_wr && op_code == PC_OP_IRQ |=> top_val == $past(pc_r))
    else $error("interrupt pushed wrong address");

  a_pin_ptr_keep: assert property (
    !pin_s2_r && !reg_wr |=> stack_ptr_r == $past(stack_ptr_r))
    else $error("pin reset moved stack pointer");

  // context copies and high latch
  a_ctx_capture: assert property (
    op_valid && op_code == PC_OP_IRQ |=>
    ctx_copy_r == $past(core_ctx) && latch_copy_r == $past(pc_high_latch_r))
    else $error("interrupt context not copied");

  a_latch_hold: assert property (
    !(reg_wr && reg_addr == ADDR_PC_LATCH) |=>
    pc_high_latch_r == $past(pc_high_latch_r))
    else $error("high latch changed without write");

  // register reads
  a_unmapped_zero: assert property (
    reg_rd && reg_addr == 13'h1fec |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero when idle");

  a_pc_low_read: assert property (
    reg_rd && reg_addr == ADDR_PC_LOW |=> reg_rdata == $past(pc_r[7:0]))
    else $error("counter low byte read wrong");

  a_ptr_read: assert property (
    reg_rd && reg_addr == ADDR_STACK_PTR |=>
    reg_rdata == {3'h0, $past(stack_ptr_r)})
    else $error("stack pointer read wrong");

  a_top_low_read: assert property (
    reg_rd && reg_addr == ADDR_STACK_TOP_LOW |=>
    reg_rdata == $past(top_val[7:0]))
    else $error("stack top low read wrong");

  a_top_high_read: assert property (
    reg_rd && reg_addr == ADDR_STACK_TOP_HIGH |=>
    reg_rdata == {1'b0, $past(top_val[14:8])})
    else $error("stack top high read wrong");

endmodule // pcl_unit

// >>> testbench/tb.sv
`timescale 1ns/100ps
module tb;
  import pcl_pkg::*;
  logic        clk_sys         = 1'b0;
  logic        rst_b           = 1'b0;
  logic        ext_pin_reset_b = 1'b1;
  logic        op_valid        = 1'b0;
  pcl_op_e     op_code         = PC_OP_STEP;
  logic [10:0] call_operand    = 11'h000;
  logic [7:0]  add_value       = 8'h00;
  pcl_ctx_s    core_ctx        = '0;
  logic [12:0] reg_addr        = 13'h0000;
  logic [7:0]  reg_wdata       = 8'h00;
  logic        reg_wr          = 1'b0;
  logic        reg_rd          = 1'b0;
  logic [7:0]  reg_rdata;
  logic [14:0] program_counter;
  logic [29:0] exp_q[$];
  logic [29:0] e;
  logic        rd_d = 1'b0;
  logic        pc_q = 1'b0;
  int          n_fail = 0;
  int          checks = 0;
  logic [6:0]  lat;
  logic [7:0]  b;
  logic [14:0] p;
  logic [14:0] pc_call;
  logic [63:0] r;
  pcl_ctx_s    cx;

  always #12.5 clk_sys = ~clk_sys;

  pcl_unit dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .ext_pin_reset_b(ext_pin_reset_b), .op_valid(op_valid),
    .op_code(op_code), .call_operand(call_operand),
    .add_value(add_value), .core_ctx(core_ctx), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .program_counter(program_counter));

  task chk(input string nm, input logic [14:0] seen, input logic [14:0] ex);
    checks++;
    if (seen !== ex)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  task give_verdict;
    if (n_fail == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // notes are {mask, masked value}; read data only stands one cycle
  always @(posedge clk_sys)
  begin
    if (rd_d)
    begin
      e = exp_q.pop_front();
      chk("reg_rdata", {7'h00, reg_rdata} & e[29:15], e[14:0]);
    end
    if (pc_q)
    begin
      e = exp_q.pop_front();
      chk("program_counter", program_counter & e[29:15], e[14:0]);
    end
    rd_d <= reg_rd;
  end

  // bus and sequencer drivers, strobes one cycle long
  task wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [12:0] a, input logic [7:0] v,
          input logic [7:0] m = 8'hff);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    exp_q.push_back({7'h00, m, 7'h00, v & m});
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask

  task pcchk(input logic [14:0] v, input logic [14:0] m = 15'h7fff);
    @(posedge clk_sys);
    pc_q <= 1'b1;
    exp_q.push_back({m, v & m});
    @(posedge clk_sys);
    pc_q <= 1'b0;
  endtask

  task op(input pcl_op_e c);
    @(posedge clk_sys);
    op_valid <= 1'b1;
    op_code  <= c;
    @(posedge clk_sys);
    op_valid <= 1'b0;
  endtask

  // hang guard: a stuck run still reaches the verdict
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    give_verdict();
  end

  initial
  begin
    void'($urandom(43991));
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    pcchk(15'h0000);
    rd(ADDR_STACK_PTR, 8'h1c);
    rd(13'h1fec, 8'h00);
    rd(13'h1fd0, 8'h00);
    lat = 7'($urandom());
    b = 8'($urandom());
    wr(ADDR_PC_LATCH, {1'b0, lat});
    wr(ADDR_PC_LOW, b);
    pcchk({lat, b});
    rd(ADDR_PC_LOW, b);
    rd(ADDR_PC_LATCH, {1'b0, lat});
    p = {lat, b} + 15'h0001;
    call_operand <= 11'($urandom());
    op(PC_OP_CALL);
    pc_call = {lat[6:3], call_operand};
    pcchk(pc_call);
    rd(ADDR_STACK_PTR, 8'h1d);
    rd(ADDR_STACK_TOP_LOW, p[7:0]);
    rd(ADDR_STACK_TOP_HIGH, {1'b0, p[14:8]});
    add_value <= 8'($urandom());
    op(PC_OP_CALL_VIA_WORKING_REG);
    pcchk({lat, add_value});
    rd(ADDR_STACK_PTR, 8'h1e);
    op(PC_OP_RETURN);
    pcchk(pc_call + 15'h0001);
    op(PC_OP_RETURN);
    pcchk(p);
    rd(ADDR_STACK_PTR, 8'h1c);
    wr(ADDR_STACK_TOP_LOW, b);
    wr(ADDR_STACK_TOP_HIGH, {1'b0, lat});
    rd(ADDR_STACK_TOP_LOW, b);
    rd(ADDR_STACK_TOP_HIGH, {1'b0, lat});
    r = {$urandom(), $urandom()};
    cx = r[55:0];
    core_ctx <= cx;
    op(PC_OP_IRQ);
    pcchk(PC_IRQ_VECTOR);
    rd(ADDR_STACK_TOP_LOW, p[7:0]);
    rd(ADDR_STATUS_COPY, cx.status, 8'h07);
    rd(ADDR_WORKING_COPY, cx.working);
    rd(ADDR_BANK_COPY, cx.bank, 8'h1f);
    rd(ADDR_LATCH_COPY, {1'b0, lat});
    rd(ADDR_PTR0L_COPY, cx.ptr0_low);
    rd(ADDR_PTR0H_COPY, cx.ptr0_high);
    rd(ADDR_PTR1L_COPY, cx.ptr1_low);
    rd(ADDR_PTR1H_COPY, cx.ptr1_high);
    // pin reset clears only the counter
    ext_pin_reset_b <= 1'b0;
    repeat (4) @(posedge clk_sys);
    ext_pin_reset_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    pcchk(15'h0000);
    rd(ADDR_WORKING_COPY, cx.working);
    rd(ADDR_STACK_PTR, 8'h1d);
    // carry out of the low byte must not reach the upper bits
    wr(ADDR_PC_LATCH, 8'h00);
    wr(ADDR_PC_LOW, 8'hff);
    add_value <= 8'hff;
    op(PC_OP_ADDLOW);
    pcchk(15'h00fe);
    // plain steps do carry into the upper bits; hold keeps the value
    op(PC_OP_STEP);
    op(PC_OP_STEP);
    pcchk(15'h0100);
    op(PC_OP_HOLD);
    pcchk(15'h0100);
    // call then return one gap apart resumes after the call
    call_operand <= 11'($urandom());
    op(PC_OP_CALL);
    op(PC_OP_RETURN);
    pcchk(15'h0101);
    rd(ADDR_STACK_PTR, 8'h1d);
    for (int i = 0; i < 4 && exp_q.size() > 0; i++)
      @(posedge clk_sys);
    if (exp_q.size() != 0)
      n_fail++;
    give_verdict();
  end
endmodule // tb
